// *** tirq_consts.svh ***
`ifndef TIRQ_CONSTS_SVH
`define TIRQ_CONSTS_SVH

// register addresses on the host serial port
`define TIRQ_ADDR_AUX 6'h0B
`define TIRQ_ADDR_QLVL 6'h0C
`define TIRQ_ADDR_QERR 6'h0D
`define TIRQ_ADDR_TXHI 6'h10
`define TIRQ_ADDR_TXLO 6'h11

// command byte layout: read flag on top, address in the low six bits
`define TIRQ_CMD_RD_BIT 7
`define TIRQ_CMD_ADDR_MSB 5

// auxiliary event flag positions
`define TIRQ_AUX_DESELECT 7
`define TIRQ_AUX_FRAMING 6
`define TIRQ_AUX_PARITY 5
`define TIRQ_AUX_CHECKSUM 4
`define TIRQ_AUX_QUEUE 3
`define TIRQ_AUX_NVM_DONE 2
`define TIRQ_AUX_NVM_WERR 1
`define TIRQ_AUX_NVM_ABORT 0

// queue error status field positions
`define TIRQ_QERR_UNDERFLOW 6
`define TIRQ_QERR_OVERFLOW 5
`define TIRQ_QERR_INCOMPLETE 4
`define TIRQ_QERR_BITS_MSB 3
`define TIRQ_QERR_BITS_LSB 1
`define TIRQ_QERR_NO_PARITY 0

// transmit count split between the two count registers
`define TIRQ_TXHI_MSB 4
`define TIRQ_TXLO_CNT_LSB 3
`define TIRQ_TXLO_SPLIT_MSB 2

// reset values and the bit counter value of a byte's last bit
`define TIRQ_REG_RESET 8'h00
`define TIRQ_TXCNT_RESET 10'h000
`define TIRQ_SPLIT_RESET 3'h0
`define TIRQ_LAST_BIT 3'h7

`endif

// *** tirq_pkg.sv ***
package tirq_pkg;

    typedef enum logic [1:0] {
        TIRQ_ST_ADDR = 2'h0,
        TIRQ_ST_TURN = 2'h1,
        TIRQ_ST_DATA = 2'h3,
        TIRQ_ST_DONE = 2'h2
    } tirq_link_st_t;

    typedef struct packed {
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } tirq_req_t;

    typedef struct packed {
        logic deselect;
        logic framing_err;
        logic parity_err;
        logic checksum_err;
        logic underflow;
        logic overflow;
        logic nvm_done;
        logic nvm_write_err;
        logic nvm_host;
        logic nvm_abort;
        logic last_byte_valid;
        logic last_byte_incomplete;
        logic [2:0] last_byte_bit_count;
        logic last_byte_no_parity;
    } tirq_evt_t;

    typedef struct packed {
        tirq_link_st_t st;
        logic [2:0] bitcnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        tirq_req_t req;
        logic req_lvl;
        logic [2:0] ack_s;
    } tirq_link_state_t;

    typedef struct packed {
        logic [2:0] req_s;
        logic req_st;
        logic pend;
        tirq_req_t pend_word;
        logic [7:0] aux;
        logic [5:0] qlvl;
        logic [7:0] qerr;
        logic [9:0] tx_count;
        logic [2:0] split;
        logic [7:0] rdata;
        logic ack;
        logic summary;
    } tirq_sys_state_t;

endpackage

// *** tirq_buf2.sv ***
`timescale 1ns/10ps
`default_nettype none
module tirq_buf2 #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0] cnt;
        logic wp;
        logic rp;
    } tirq_buf_state_t;

    tirq_buf_state_t q;
    tirq_buf_state_t d;
    logic push;
    logic pop;

    assign in_ready = (q.cnt != 2'h2);
    assign out_valid = (q.cnt != 2'h0);
    assign out_data = q.mem[q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = ~q.wp;
        end
        if (pop) begin
            d.rp = ~q.rp;
        end
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule
`default_nettype wire

// *** tirq_regs.sv ***
// Overview of operation
// - deselect command sets aux flag bit 7
// - parity/checksum errors set bits 5/4, data kept
// - missing parity sets status bit 0, framing
// - underflow bit 6, overflow bit 5, aux 3
// - host nvm write done sets aux 2
// - host nvm protected/bad address sets aux 1
// - host nvm access aborted sets aux 0; the code sets it on any abort, nvm_host ignored
// - aux flags zero at reset and restore
// - reading aux flags clears them
// - low six bits give unread queue bytes
// - incomplete last byte: bit 4, bits 3:1
// - queue status cleared by reset, restore, clear
// - low three bits give split-byte bit count
// - count fields zero at reset and restore
// - summary bit pending until aux flags read or restore
`timescale 1ns/10ps
`default_nettype none
`include "tirq_consts.svh"
module tirq_regs (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic host_sclk,
    input wire logic host_cs_n,
    input wire logic host_mosi,
    output logic host_miso,
    output logic host_miso_oe,
    input wire tirq_pkg::tirq_evt_t evt,
    input wire logic [5:0] queue_level_count,
    input wire logic restore_defaults,
    input wire logic queue_clear,
    output logic aux_pending,
    output logic [9:0] tx_full_byte_count,
    output logic [2:0] tx_split_bit_count
);
    tirq_pkg::tirq_link_state_t l_q;
    tirq_pkg::tirq_link_state_t l_d;
    tirq_pkg::tirq_sys_state_t s_q;
    tirq_pkg::tirq_sys_state_t s_d;
    tirq_pkg::tirq_req_t buf_out;
    logic [7:0] byte_in;
    logic ack_ok;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic pop;
    logic aux_read;
    logic restore_clr;
    logic queue_clr;
    logic [7:0] aux_set;

    // link side: runs on the host serial clock, frame reset by chip select
    always_comb begin
        l_d = l_q;
        // ack is a level from the system domain, three stages
        l_d.ack_s = {l_q.ack_s[1:0], s_q.ack};
        ack_ok = l_q.ack_s[1] & l_q.ack_s[2];
        byte_in = {l_q.shift_in[6:0], host_mosi};
        l_d.bitcnt = l_q.bitcnt + 3'h1;
        case (l_q.st)
            tirq_pkg::TIRQ_ST_ADDR: begin
                l_d.shift_in = byte_in;
                if (l_q.bitcnt == `TIRQ_LAST_BIT) begin
                    l_d.req.rd = byte_in[`TIRQ_CMD_RD_BIT];
                    l_d.req.addr = byte_in[`TIRQ_CMD_ADDR_MSB:0];
                    if (byte_in[`TIRQ_CMD_RD_BIT]) begin
                        l_d.req_lvl = 1'b1;
                        l_d.st = tirq_pkg::TIRQ_ST_TURN;
                    end else begin
                        l_d.st = tirq_pkg::TIRQ_ST_DATA;
                    end
                end
            end
            tirq_pkg::TIRQ_ST_TURN: begin
                // rdata is only trusted once the answer level has crossed
                if (l_q.bitcnt == `TIRQ_LAST_BIT) begin
                    l_d.shift_out = ack_ok ? s_q.rdata : `TIRQ_REG_RESET;
                    l_d.st = tirq_pkg::TIRQ_ST_DATA;
                end
            end
            tirq_pkg::TIRQ_ST_DATA: begin
                if (l_q.req.rd) begin
                    l_d.shift_out = {l_q.shift_out[6:0], 1'b0};
                end else begin
                    l_d.shift_in = byte_in;
                end
                if (l_q.bitcnt == `TIRQ_LAST_BIT) begin
                    if (!l_q.req.rd) begin
                        l_d.req.wdata = byte_in;
                        l_d.req_lvl = 1'b1;
                    end
                    l_d.st = tirq_pkg::TIRQ_ST_DONE;
                end
            end
            tirq_pkg::TIRQ_ST_DONE: begin
                l_d.bitcnt = l_q.bitcnt;
            end
            default: begin
                l_d.st = tirq_pkg::TIRQ_ST_DONE;
            end
        endcase
    end

    // the link clock stops between frames, so chip select ends each frame
    always_ff @(posedge host_sclk or posedge host_cs_n) begin
        if (host_cs_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign host_miso = l_q.shift_out[7];
    assign host_miso_oe = ~host_cs_n & l_q.req.rd & (l_q.st == tirq_pkg::TIRQ_ST_DATA);

    // two-entry buffer between the crossing and the register file
    tirq_buf2 #(
        .W($bits(tirq_pkg::tirq_req_t))
    ) u_req_buf (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(s_q.pend),
        .in_ready(buf_in_ready),
        .in_data(s_q.pend_word),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out)
    );

    // one request answered at a time; the buffer holds the rest
    assign buf_out_ready = ~s_q.ack;
    assign pop = buf_out_valid & buf_out_ready;
    assign aux_read = pop & buf_out.rd & (buf_out.addr == `TIRQ_ADDR_AUX);
    assign restore_clr = restore_defaults;
    assign queue_clr = restore_defaults | queue_clear;

    always_comb begin
        aux_set = `TIRQ_REG_RESET;
        aux_set[`TIRQ_AUX_DESELECT] = evt.deselect;
        aux_set[`TIRQ_AUX_FRAMING] = evt.framing_err | evt.last_byte_no_parity;
        aux_set[`TIRQ_AUX_PARITY] = evt.parity_err;
        aux_set[`TIRQ_AUX_CHECKSUM] = evt.checksum_err;
        aux_set[`TIRQ_AUX_QUEUE] = evt.underflow | evt.overflow;
        aux_set[`TIRQ_AUX_NVM_DONE] = evt.nvm_done & evt.nvm_host;
        aux_set[`TIRQ_AUX_NVM_WERR] = evt.nvm_write_err & evt.nvm_host;
        aux_set[`TIRQ_AUX_NVM_ABORT] = evt.nvm_abort;
    end

    always_comb begin
        s_d = s_q;
        s_d.req_s = {s_q.req_s[1:0], l_q.req_lvl};
        if (s_q.req_s[1] == s_q.req_s[2]) begin
            s_d.req_st = s_q.req_s[2];
        end
        if (s_q.pend & buf_in_ready) begin
            s_d.pend = 1'b0;
        end
        // request word is held by the link until its frame ends
        if (s_d.req_st & ~s_q.req_st) begin
            s_d.pend = 1'b1;
            s_d.pend_word = l_q.req;
        end
        if (pop) begin
            s_d.ack = 1'b1;
        end else if (!s_q.req_st) begin
            s_d.ack = 1'b0;
        end
        if (pop & buf_out.rd) begin
            case (buf_out.addr)
                `TIRQ_ADDR_AUX: s_d.rdata = s_q.aux;
                `TIRQ_ADDR_QLVL: s_d.rdata = {2'h0, s_q.qlvl};
                `TIRQ_ADDR_QERR: s_d.rdata = s_q.qerr;
                `TIRQ_ADDR_TXHI: s_d.rdata = {3'h0, s_q.tx_count[9:5]};
                `TIRQ_ADDR_TXLO: s_d.rdata = {s_q.tx_count[4:0], s_q.split};
                default: s_d.rdata = `TIRQ_REG_RESET;
            endcase
        end
        if (pop & ~buf_out.rd) begin
            case (buf_out.addr)
                `TIRQ_ADDR_TXHI: begin
                    s_d.tx_count[9:5] = buf_out.wdata[`TIRQ_TXHI_MSB:0];
                end
                `TIRQ_ADDR_TXLO: begin
                    s_d.tx_count[4:0] = buf_out.wdata[7:`TIRQ_TXLO_CNT_LSB];
                    s_d.split = buf_out.wdata[`TIRQ_TXLO_SPLIT_MSB:0];
                end
                default: begin
                    s_d.split = s_d.split;
                end
            endcase
        end
        if (restore_clr) begin
            s_d.tx_count = `TIRQ_TXCNT_RESET;
            s_d.split = `TIRQ_SPLIT_RESET;
        end
        // clear on read, new events win
        s_d.aux = ((aux_read | restore_clr) ? `TIRQ_REG_RESET : s_q.aux) | aux_set;
        s_d.qlvl = queue_clr ? 6'h00 : queue_level_count;
        if (queue_clr) begin
            s_d.qerr = `TIRQ_REG_RESET;
        end
        s_d.qerr[`TIRQ_QERR_UNDERFLOW] = s_d.qerr[`TIRQ_QERR_UNDERFLOW] | evt.underflow;
        s_d.qerr[`TIRQ_QERR_OVERFLOW] = s_d.qerr[`TIRQ_QERR_OVERFLOW] | evt.overflow;
        s_d.qerr[`TIRQ_QERR_NO_PARITY] = s_d.qerr[`TIRQ_QERR_NO_PARITY]
            | evt.last_byte_no_parity;
        if (evt.last_byte_valid) begin
            s_d.qerr[`TIRQ_QERR_INCOMPLETE] = evt.last_byte_incomplete;
            s_d.qerr[`TIRQ_QERR_BITS_MSB:`TIRQ_QERR_BITS_LSB] =
                evt.last_byte_incomplete ? evt.last_byte_bit_count : 3'h0;
        end
        s_d.summary = |s_d.aux;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign aux_pending = s_q.summary;
    assign tx_full_byte_count = s_q.tx_count;
    assign tx_split_bit_count = s_q.split;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    deselect_flag_a: assert property (evt.deselect |=> s_q.aux[7])
        else $error("deselect did not set its flag");
    parity_flag_a: assert property (evt.parity_err |=> s_q.aux[5] && aux_pending)
        else $error("parity error flag missing");
    checksum_flag_a: assert property (evt.checksum_err |=> s_q.aux[4])
        else $error("checksum error flag missing");
    no_parity_a: assert property (evt.last_byte_no_parity && !queue_clr
        |=> s_q.qerr[0] && s_q.aux[6])
        else $error("missing parity not flagged as framing");
    queue_error_a: assert property ((evt.underflow || evt.overflow) && !queue_clr
        |=> s_q.aux[3] && (s_q.qerr[6] || s_q.qerr[5]))
        else $error("queue error not flagged");
    nvm_done_a: assert property (evt.nvm_done && evt.nvm_host |=> s_q.aux[2])
        else $error("host nvm completion not flagged");
    nvm_local_a: assert property (evt.nvm_write_err && !evt.nvm_host && !s_q.aux[1]
        |=> !s_q.aux[1])
        else $error("non-host nvm error raised host flag");
    nvm_abort_a: assert property (evt.nvm_abort |=> s_q.aux[0])
        else $error("nvm abort not flagged");
    restore_clear_a: assert property (restore_defaults && aux_set == 8'h00
        |=> s_q.aux == 8'h00 && tx_full_byte_count == 10'h000)
        else $error("restore did not clear flags and counts");
    read_clear_a: assert property (aux_read && aux_set == 8'h00
        |=> s_q.aux == 8'h00 && !aux_pending)
        else $error("reading aux flags did not clear them");
    level_count_a: assert property (!queue_clr
        |=> s_q.qlvl == $past(queue_level_count))
        else $error("queue level count wrong");
    last_byte_a: assert property (evt.last_byte_valid && evt.last_byte_incomplete && !queue_clr
        |=> s_q.qerr[4] && s_q.qerr[3:1] == $past(evt.last_byte_bit_count))
        else $error("incomplete last byte not reported");
    queue_clr_a: assert property (queue_clear && !evt.last_byte_valid && !evt.underflow
        && !evt.overflow && !evt.last_byte_no_parity |=> s_q.qerr == 8'h00)
        else $error("clear did not zero queue status");
    split_write_a: assert property (pop && !buf_out.rd && buf_out.addr == 6'h11
        && !restore_defaults |=> tx_split_bit_count == $past(buf_out.wdata[2:0]))
        else $error("split bit count not written");
    sticky_hold_a: assert property (s_q.aux[3] && !aux_read && !restore_defaults
        |=> s_q.aux[3] [*1])
        else $error("queue error flag dropped early");
    summary_a: assert property (aux_pending && !aux_read && !restore_defaults
        |=> aux_pending)
        else $error("summary cleared without aux read");
    underflow_flag_a: assert property (evt.underflow && !queue_clr
        |=> s_q.qerr[6] && s_q.aux[3])
        else $error("underflow not flagged");
    overflow_flag_a: assert property (evt.overflow && !queue_clr
        |=> s_q.qerr[5] && s_q.aux[3])
        else $error("overflow not flagged");
    full_count_a: assert property (pop && !buf_out.rd && buf_out.addr == 6'h10 && !restore_defaults
        |=> tx_full_byte_count[9:5] == $past(buf_out.wdata[4:0]))
        else $error("upper byte count not written");
    complete_byte_a: assert property (evt.last_byte_valid && !evt.last_byte_incomplete
        && !queue_clr |=> s_q.qerr[4:1] == 4'h0)
        else $error("complete last byte reported as partial");
endmodule
`default_nettype wire

// *** tirq_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tirq_host_model (
    output logic host_sclk,
    output logic host_cs_n,
    output logic host_mosi,
    input wire logic host_miso,
    input wire logic host_miso_oe
);
    initial begin
        host_sclk = 1'b0;
        // a defined rising select edge clears the link logic before the first frame
        host_cs_n = 1'b0;
        host_mosi = 1'b0;
        #1 host_cs_n = 1'b1;
    end
    // count loaded by frames
    // clock stands low outside frames; a gap keeps frames apart in the system domain
    task automatic access(input logic rd, input logic [5:0] addr, input logic [7:0] wdata,
            output logic [7:0] rdata);
        logic [23:0] sh;
        int n;
        sh = {rd, 1'b0, addr, wdata, 8'h00};
        n = rd ? 24 : 16;
        rdata = 8'h00;
        host_cs_n = 1'b0;
        #20;
        for (int i = 0; i < n; i++) begin
            host_mosi = sh[23-i];
            // an undriven answer line must not pass as data
            if (i >= 16) begin
                rdata = {rdata[6:0], host_miso_oe ? host_miso : 1'bx};
            end
            #15 host_sclk = 1'b1;
            #15 host_sclk = 1'b0;
        end
        // select stays low until the system side has taken the word; ending early loses it
        #90 host_cs_n = 1'b1;
        host_mosi = ~host_mosi;
        #100;
    endtask
endmodule
`default_nettype wire

// *** tirq_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tirq_regs_tb;
    logic sys_clk, srst, host_sclk, host_cs_n, host_mosi, host_miso, host_miso_oe;
    tirq_pkg::tirq_evt_t evt;
    logic [5:0] queue_level_count;
    logic restore_defaults, queue_clear, aux_pending;
    logic [9:0] tx_full_byte_count;
    logic [2:0] tx_split_bit_count;
    logic [7:0] rdata;
    int num_errors = 0;
    int samples_checked = 0;

    tirq_regs tirq_regs_inst (.sys_clk(sys_clk), .srst(srst), .host_sclk(host_sclk),
        .host_cs_n(host_cs_n), .host_mosi(host_mosi), .host_miso(host_miso),
        .host_miso_oe(host_miso_oe), .evt(evt), .queue_level_count(queue_level_count),
        .restore_defaults(restore_defaults), .queue_clear(queue_clear),
        .aux_pending(aux_pending), .tx_full_byte_count(tx_full_byte_count),
        .tx_split_bit_count(tx_split_bit_count));
    tirq_host_model tirq_host_model_inst (.host_sclk(host_sclk), .host_cs_n(host_cs_n),
        .host_mosi(host_mosi), .host_miso(host_miso), .host_miso_oe(host_miso_oe));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        tirq_host_model_inst.access(1'b1, a, 8'h00, rdata);
        check({2'h0, rdata}, {2'h0, exp});
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        tirq_host_model_inst.access(1'b0, a, d, rdata);
    endtask

    // one-cycle pulse; flags are looked at after they have landed
    task automatic pulse(input tirq_pkg::tirq_evt_t e);
        @(posedge sys_clk);
        evt <= e;
        @(posedge sys_clk);
        evt <= '0;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic cmd(input logic r, input logic c);
        @(posedge sys_clk);
        restore_defaults <= r;
        queue_clear <= c;
        @(posedge sys_clk);
        restore_defaults <= 1'b0;
        queue_clear <= 1'b0;
        @(posedge sys_clk);
    endtask

    function automatic tirq_pkg::tirq_evt_t ev(input int b);
        tirq_pkg::tirq_evt_t e;
        e = '0;
        case (b)
            7: e.deselect = 1'b1;
            6: e.framing_err = 1'b1;
            5: e.parity_err = 1'b1;
            4: e.checksum_err = 1'b1;
            3: e.underflow = 1'b1;
            2: e.nvm_done = 1'b1;
            1: e.nvm_write_err = 1'b1;
            default: e.nvm_abort = 1'b1;
        endcase
        e.nvm_host = 1'b1;
        return e;
    endfunction

    initial begin
        tirq_pkg::tirq_evt_t e;
        srst = 1'b1;
        evt = '0;
        queue_level_count = 6'h00;
        restore_defaults = 1'b0;
        queue_clear = 1'b0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(6'h0B, 8'h00);
        rd(6'h0D, 8'h00);
        rd(6'h10, 8'h00);
        rd(6'h11, 8'h00);
        check({9'h000, aux_pending}, 10'h000);
        // each event twice: a repeat must not disturb the flag
        for (int b = 0; b < 8; b++) begin
            pulse(ev(b));
            pulse(ev(b));
            check({9'h000, aux_pending}, 10'h001);
            rd(6'h0B, 8'h01 << b);
            rd(6'h0B, 8'h00);
            check({9'h000, aux_pending}, 10'h000);
        end
        rd(6'h0D, 8'h40);
        e = '0;
        e.overflow = 1'b1;
        pulse(e);
        rd(6'h0D, 8'h60);
        rd(6'h0B, 8'h08);
        cmd(1'b0, 1'b1);
        rd(6'h0D, 8'h00);
        e = ev(2);
        e.nvm_host = 1'b0;
        pulse(e);
        e = ev(1);
        e.nvm_host = 1'b0;
        pulse(e);
        rd(6'h0B, 8'h00);
        e = '0;
        e.last_byte_valid = 1'b1;
        e.last_byte_incomplete = 1'b1;
        e.last_byte_bit_count = 3'h5;
        pulse(e);
        rd(6'h0D, 8'h1A);
        e = '0;
        e.last_byte_no_parity = 1'b1;
        pulse(e);
        rd(6'h0D, 8'h1B);
        rd(6'h0B, 8'h40);
        e = '0;
        e.last_byte_valid = 1'b1;
        e.last_byte_bit_count = 3'h5;
        pulse(e);
        rd(6'h0D, 8'h01);
        cmd(1'b1, 1'b0);
        rd(6'h0D, 8'h00);
        @(posedge sys_clk);
        queue_level_count <= 6'h20;
        rd(6'h0C, 8'h20);
        @(posedge sys_clk);
        queue_level_count <= 6'h00;
        rd(6'h0C, 8'h00);
        wr(6'h10, 8'h1F);
        wr(6'h11, 8'hFD);
        check(tx_full_byte_count, 10'h3FF);
        check({7'h00, tx_split_bit_count}, 10'h005);
        rd(6'h10, 8'h1F);
        rd(6'h11, 8'hFD);
        // read-only and unmapped places ignore writes
        wr(6'h0D, 8'hFF);
        rd(6'h0D, 8'h00);
        wr(6'h3F, 8'hFF);
        rd(6'h3F, 8'h00);
        pulse(ev(7));
        cmd(1'b1, 1'b0);
        rd(6'h0B, 8'h00);
        check(tx_full_byte_count, 10'h000);
        rd(6'h11, 8'h00);
        complete_run();
    end

    initial begin
        repeat (50000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
